// *** hdl/pin_change_pkg.sv ***
// Constants, register map and carrier types of the pin change interrupt unit.
// Assumes a 32-bit classic Wishbone slave port and a 10 MHz system clock.
package pin_change_pkg;

  localparam int GROUPS      = 4;
  localparam int GROUP_WIDTH = 8;
  localparam int PINS        = GROUPS * GROUP_WIDTH;
  localparam int ADR_WIDTH   = 10;
  localparam int SYNC_STAGES = 2;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] FLAG_IDX    = 8'h1B;
  localparam logic [7:0] CONTROL_IDX = 8'h68;
  localparam logic [7:0] MASK0_IDX   = 8'h6B;
  localparam logic [7:0] MASK1_IDX   = 8'h6C;
  localparam logic [7:0] MASK2_IDX   = 8'h6D;
  localparam logic [7:0] MASK3_IDX   = 8'h73;

  // Reset values
  localparam logic [7:0] FLAG_RESET    = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h00;

  // Field layout of flag and control registers: groups in bits 3..0
  localparam int GROUP_LSB = 0;

  // Request towards the processor: lowest group number wins
  typedef struct packed {
    logic       valid;
    logic [1:0] group;
  } vector_s;

  // One register access as seen by the register file
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] idx;
    logic [7:0] data;
  } reg_access_s;

endpackage : pin_change_pkg

// *** hdl/pin_change_detect.sv ***
// Two-stage synchroniser and change detector for the watched pins.
// Assumes pins_i levels are taken on clk_i; ce_i low freezes every stage.
`timescale 1ns/1ns
module pin_change_detect #(
  parameter int WIDTH  = 32,
  parameter int STAGES = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] pins_i,
  output logic      [WIDTH-1:0] change_o
);

  logic [WIDTH-1:0] sync_q [STAGES];
  logic [WIDTH-1:0] prev_q;

  // Synchroniser chain; stage 0 feeds only stage 1 to keep metastability contained
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int s = 0; s < STAGES; s++) sync_q[s] <= '0;
      prev_q <= '0;
    end else if (ce_i) begin
      sync_q[0] <= pins_i;
      for (int s = 1; s < STAGES; s++) sync_q[s] <= sync_q[s-1];
      prev_q <= sync_q[STAGES-1];
    end
  end

  // Either edge counts, so a plain difference is enough
  assign change_o = sync_q[STAGES-1] ^ prev_q;

endmodule : pin_change_detect

// *** hdl/vector_select.sv ***
// Fixed-priority selector of the group vector presented to the processor.
// Assumes the processor takes the lowest numbered pending group first.
`timescale 1ns/1ns
module vector_select (
  input  wire logic [3:0]      pending_i,
  output pin_change_pkg::vector_s vector_o
);

  // Lowest group number has the highest priority
  assign vector_o.valid = |pending_i;
  assign vector_o.group = pending_i[0] ? 2'h0 :
                          pending_i[1] ? 2'h1 :
                          pending_i[2] ? 2'h2 : 2'h3;

endmodule : vector_select

// *** hdl/pin_change_irq.sv ***
// Pin change interrupt unit: 32 pins in four groups, registers on Wishbone.
// Assumes a classic Wishbone master and a processor that acknowledges vectors.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ns
module pin_change_irq #(
  parameter int ADR_W = pin_change_pkg::ADR_WIDTH
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  input  wire logic [ADR_W-1:0]              adr_i,
  input  wire logic [31:0]                   dat_i,
  output logic      [31:0]                   dat_o,
  input  wire logic                          we_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  output logic                               ack_o,
  input  wire logic [pin_change_pkg::PINS-1:0] pins_i,
  input  wire logic                          global_irq_enable_i,
  input  wire logic                          vector_ack_i,
  input  wire logic [1:0]                    vector_ack_group_i,
  output logic      [3:0]                    group_vector_req_o,
  output pin_change_pkg::vector_s            vector_o,
  output logic                               irq_o
);

  localparam int G = pin_change_pkg::GROUPS;
  localparam int W = pin_change_pkg::GROUP_WIDTH;

  // Returns the mask group addressed by an index, or 4 when none
  function automatic logic [2:0] mask_group(input logic [7:0] idx);
    unique case (idx)
      pin_change_pkg::MASK0_IDX: mask_group = 3'h0;
      pin_change_pkg::MASK1_IDX: mask_group = 3'h1;
      pin_change_pkg::MASK2_IDX: mask_group = 3'h2;
      pin_change_pkg::MASK3_IDX: mask_group = 3'h3;
      default:                   mask_group = 3'h4;
    endcase
  endfunction : mask_group

  logic [W-1:0]   mask_q [G];
  logic [G-1:0]   group_irq_enable_q;
  logic [G-1:0]   group_change_flag_q;
  logic [G-1:0]   group_change_flag_d;
  logic           ack_q;
  logic [31:0]    dat_q;
  logic [G*W-1:0] change;
  logic [G-1:0]   flag_set;
  logic [G-1:0]   flag_clr;
  logic [G-1:0]   handler_clr;
  logic [G-1:0]   armed;
  pin_change_pkg::reg_access_s acc;
  logic [2:0]     acc_mask_group;
  logic [7:0]     rd_value;

  pin_change_detect #(
    .WIDTH  (pin_change_pkg::PINS),
    .STAGES (pin_change_pkg::SYNC_STAGES)
  ) u_detect (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .pins_i   (pins_i),
    .change_o (change)
  );

  // Bus decode: a write takes effect on the edge where ack is seen by the master
  assign acc.wr   = cyc_i && stb_i && we_i && ack_q && sel_i[0];
  assign acc.rd   = cyc_i && stb_i && !we_i && !ack_q;
  assign acc.idx  = adr_i[ADR_W-1:2];
  assign acc.data = dat_i[7:0];
  assign acc_mask_group = mask_group(acc.idx);

  // Read mux; unmapped addresses read zero but are still acknowledged
  assign rd_value =
    (acc.idx == pin_change_pkg::FLAG_IDX)    ? {4'h0, group_change_flag_q} :
    (acc.idx == pin_change_pkg::CONTROL_IDX) ? {4'h0, group_irq_enable_q}  :
    (acc_mask_group != 3'h4)                 ? mask_q[acc_mask_group[1:0]] : 8'h00;

  // Single wait state: ack rises one edge after the request and drops after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= cyc_i && stb_i && !ack_q;
      if (acc.rd) dat_q <= {24'h00_0000, rd_value};
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // Per-group mask registers; bit n of group k watches pin 8k+n
  for (genvar k = 0; k < G; k++) begin : g_mask
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mask_q[k] <= pin_change_pkg::MASK_RESET;
      end else if (ce_i && acc.wr && acc_mask_group == 3'(k)) begin
        mask_q[k] <= acc.data;
      end
    end

    // A pin counts only when masked in and its group enabled
    assign flag_set[k] = group_irq_enable_q[k] && |(change[k*W +: W] & mask_q[k]);
    assign handler_clr[k] = vector_ack_i && vector_ack_group_i == 2'(k);
  end

  // Write one clears; a change in the same cycle wins over the clear
  assign flag_clr = (acc.wr && acc.idx == pin_change_pkg::FLAG_IDX)
                    ? acc.data[G-1:0] : '0;
  assign group_change_flag_d = flag_set | (group_change_flag_q & ~(flag_clr | handler_clr));

  // Control and flag registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      group_irq_enable_q  <= pin_change_pkg::CONTROL_RESET[G-1:0];
      group_change_flag_q <= pin_change_pkg::FLAG_RESET[G-1:0];
    end else if (ce_i) begin
      if (acc.wr && acc.idx == pin_change_pkg::CONTROL_IDX) begin
        group_irq_enable_q <= acc.data[G-1:0];
      end
      group_change_flag_q <= group_change_flag_d;
    end
  end

  // Arming needs both the group enable and the processor's global enable
  assign armed              = group_irq_enable_q & {G{global_irq_enable_i}};
  assign group_vector_req_o = group_change_flag_q & armed;
  assign irq_o              = |group_vector_req_o;

  vector_select u_select (
    .pending_i (group_vector_req_o),
    .vector_o  (vector_o)
  );

  // Checks of the behaviour above
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  for (genvar k = 0; k < G; k++) begin : g_chk
    a_flag_on_change: assert property (
      ce_i && group_irq_enable_q[k] && |(change[k*W +: W] & mask_q[k])
      |=> group_change_flag_q[k])
      else $error("group flag not set after watched pin change");

    a_masked_pin_quiet: assert property (
      ce_i && !group_change_flag_q[k] && (!group_irq_enable_q[k] || mask_q[k] == 8'h00)
      |=> !group_change_flag_q[k])
      else $error("flag set without enabled watched pin");

    a_vector_needs_all: assert property (
      group_vector_req_o[k] |->
      group_change_flag_q[k] && group_irq_enable_q[k] && global_irq_enable_i)
      else $error("vector request without flag and both enables");

    a_armed_vectors: assert property (
      group_change_flag_q[k] && group_irq_enable_q[k] && global_irq_enable_i
      |-> group_vector_req_o[k] && irq_o)
      else $error("armed pending group not requested");

    a_handler_clear: assert property (
      ce_i && handler_clr[k] && !flag_set[k] |=> !group_change_flag_q[k])
      else $error("handler did not clear group flag");

    a_flag_w1c: assert property (
      ce_i && flag_clr[k] && !flag_set[k] |=> !group_change_flag_q[k])
      else $error("writing one did not clear flag");

    a_flag_zero_keeps: assert property (
      ce_i && group_change_flag_q[k] && !flag_clr[k] && !handler_clr[k]
      |=> group_change_flag_q[k])
      else $error("flag lost without a clear");
  end

  a_reset_all_zero: assert property (
    $past(rst_i) |-> group_irq_enable_q == '0 && group_change_flag_q == '0
    && mask_q[0] == 8'h00 && mask_q[3] == 8'h00)
    else $error("registers not zero after reset");

  a_ack_single_cycle: assert property (
    ce_i && ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_vector_lowest: assert property (
    group_vector_req_o[0] |-> vector_o.valid && vector_o.group == 2'h0)
    else $error("group 0 vector not selected first");

  a_mask_write: assert property (
    ce_i && acc.wr && acc.idx == pin_change_pkg::MASK3_IDX
    |=> mask_q[3] == $past(dat_i[7:0]))
    else $error("group 3 mask not written");

  // Every register must hold still while the clock enable is low, and may only
  // move for its own reason otherwise; a stray update here would show up to
  // software as a spurious interrupt rather than as a bus error.
  for (genvar k = 0; k < G; k++) begin : g_hold
    a_freeze_flag: assert property (
      !ce_i |=> $stable(group_change_flag_q[k]))
      else $error("flag moved while clock enable low");

    a_freeze_mask: assert property (
      !ce_i |=> $stable(mask_q[k]))
      else $error("mask moved while clock enable low");

    a_freeze_enable: assert property (
      !ce_i |=> $stable(group_irq_enable_q[k]))
      else $error("enable moved while clock enable low");

    a_freeze_change: assert property (
      !ce_i |=> $stable(change[k*W +: W]))
      else $error("change detector moved while clock enable low");

    // A flag may only rise from a watched change seen one edge earlier
    a_flag_has_cause: assert property (
      $rose(group_change_flag_q[k]) |-> $past(ce_i && flag_set[k]))
      else $error("flag rose without a watched change");

    a_change_needs_mask: assert property (
      ce_i && !group_change_flag_q[k] && (change[k*W +: W] & mask_q[k]) == 8'h00
      |=> !group_change_flag_q[k])
      else $error("flag set by a pin whose mask bit is clear");

    // Masks and enables change only by a write addressed to them
    a_mask_kept: assert property (
      ce_i && !(acc.wr && acc_mask_group == 3'(k)) |=> $stable(mask_q[k]))
      else $error("mask changed without a write to it");

    a_mask_loaded: assert property (
      ce_i && acc.wr && acc_mask_group == 3'(k) |=> mask_q[k] == $past(dat_i[7:0]))
      else $error("mask write did not land");

    a_enable_kept: assert property (
      ce_i && !(acc.wr && acc.idx == pin_change_pkg::CONTROL_IDX)
      |=> $stable(group_irq_enable_q[k]))
      else $error("group enable changed without a write");

    a_reset_mask_zero: assert property (
      $past(rst_i) |-> mask_q[k] == pin_change_pkg::MASK_RESET)
      else $error("mask not zero after reset");

    // Requests need both enables; the vector never skips a lower pending group
    a_global_gates: assert property (
      !global_irq_enable_i || !group_irq_enable_q[k] |-> !group_vector_req_o[k])
      else $error("request without both enables");

    a_vector_priority: assert property (
      group_vector_req_o[k] |-> vector_o.valid && vector_o.group <= 2'(k))
      else $error("higher group vector chosen over lower");
  end

  // Bus timing: exactly one wait state, no ack that was not asked for
  a_ack_one_wait: assert property (
    ce_i && cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged after one wait state");

  a_ack_needs_req: assert property (
    ce_i && !(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without a request");

  a_freeze_ack: assert property (
    !ce_i |=> $stable(ack_o) && $stable(dat_o))
    else $error("bus outputs moved while clock enable low");

  // Read data comes from flops loaded on the taking edge, so it is checked
  // one edge later against what the register held at the taking edge
  a_dat_upper_zero: assert property (
    dat_o[31:8] == 24'h00_0000)
    else $error("read data upper lanes not zero");

  a_read_control: assert property (
    ce_i && acc.rd && acc.idx == pin_change_pkg::CONTROL_IDX
    |=> dat_o[7:0] == {4'h0, $past(group_irq_enable_q)})
    else $error("control read back wrong");

  a_read_flags: assert property (
    ce_i && acc.rd && acc.idx == pin_change_pkg::FLAG_IDX
    |=> dat_o[7:0] == {4'h0, $past(group_change_flag_q)})
    else $error("flags read back wrong");

  a_read_mask0: assert property (
    ce_i && acc.rd && acc.idx == pin_change_pkg::MASK0_IDX
    |=> dat_o[7:0] == $past(mask_q[0]))
    else $error("group 0 mask read back wrong");

  a_read_mask3: assert property (
    ce_i && acc.rd && acc.idx == pin_change_pkg::MASK3_IDX
    |=> dat_o[7:0] == $past(mask_q[3]))
    else $error("group 3 mask read back wrong");

  a_read_unmapped: assert property (
    ce_i && acc.rd && acc_mask_group == 3'h4 && acc.idx != pin_change_pkg::FLAG_IDX
    && acc.idx != pin_change_pkg::CONTROL_IDX |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  // A write with byte lane 0 off must leave every register alone
  a_lane_off_ignored: assert property (
    ce_i && cyc_i && stb_i && we_i && ack_o && !sel_i[0]
    |=> $stable(group_irq_enable_q) && $stable(mask_q[0]))
    else $error("write with lane 0 off took effect");

  // The vector and the irq output follow the request lines
  a_vector_points_pending: assert property (
    vector_o.valid |-> group_vector_req_o[vector_o.group])
    else $error("vector names a group with no request");

  a_irq_follows_requests: assert property (
    irq_o == (group_vector_req_o != 4'h0))
    else $error("irq output disagrees with requests");

endmodule : pin_change_irq

// *** bench/pin_partner.sv ***
// Far-side model: the processor core that takes pin change vectors.
// Assumes one clock; the bench sets the service mode and the response lag.
`timescale 1ns/1ns
module pin_partner (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    serve_i,
  input  wire logic [3:0]              lag_i,
  input  wire pin_change_pkg::vector_s vector_i,
  output logic                         vector_ack_o,
  output logic [1:0]                   vector_ack_group_o
);
  logic [3:0] cnt_q;

  // Runs the handler lag_i+1 cycles after a vector appears; one pulse per entry
  always_ff @(posedge clk_i) begin
    vector_ack_o       <= 1'b0;
    vector_ack_group_o <= vector_i.group;
    if (rst_i || !serve_i || !vector_i.valid || vector_ack_o) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == lag_i) begin
      vector_ack_o <= 1'b1;
      cnt_q        <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : pin_partner

// *** bench/tb_pin_change_irq.sv ***
// Self-checking bench of the pin change unit, registers over Wishbone.
// Assumes one wait state on the bus and a flag three edges after a pin change.
`timescale 1ns/1ns
module tb_pin_change_irq;
  localparam logic [7:0] IDX [6] = '{pin_change_pkg::FLAG_IDX, pin_change_pkg::CONTROL_IDX,
    pin_change_pkg::MASK0_IDX, pin_change_pkg::MASK1_IDX, pin_change_pkg::MASK2_IDX,
    pin_change_pkg::MASK3_IDX};
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic [9:0]              adr_i = 10'h000;
  logic [31:0]             dat_i = 32'h0;
  logic                    we_i  = 1'b0;
  logic                    cyc_i = 1'b0;
  logic                    stb_i = 1'b0;
  logic [3:0]              sel_i = 4'h0;
  logic [31:0]             pins  = 32'h0;
  logic                    gie   = 1'b0;
  logic                    serve = 1'b0;
  logic                    ce    = 1'b1;
  logic [3:0]              lane  = 4'h1;
  logic [31:0]             dat_o, rd;
  logic                    ack_o, irq_o, v_ack;
  logic [1:0]              v_grp;
  logic [3:0]              req_o;
  pin_change_pkg::vector_s vec;
  int                      n_fail = 0, comparisons = 0, cycles = 0;

  initial forever #50 clk_i = ~clk_i;

  pin_change_irq dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .pins_i(pins), .global_irq_enable_i(gie), .vector_ack_i(v_ack),
    .vector_ack_group_i(v_grp), .group_vector_req_o(req_o), .vector_o(vec), .irq_o(irq_o));

  pin_partner cpu (.clk_i(clk_i), .rst_i(rst_i), .serve_i(serve), .lag_i(4'h3),
    .vector_i(vec), .vector_ack_o(v_ack), .vector_ack_group_o(v_grp));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // One classic cycle, entered just after an edge; request held until ack is seen
  task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] wd);
    int n;
    n = 0;
    adr_i <= {idx, 2'b00};
    we_i  <= w;
    dat_i <= {24'h0, wd};
    sel_i <= lane;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
    wb(idx, 1'b0, 8'h00);
    check(rd, {24'h0, e});
  endtask : rdchk

  // Flips pins, then waits out the synchroniser and flag latency
  task automatic flip(input logic [31:0] m);
    pins <= pins ^ m;
    repeat (5) @(posedge clk_i);
  endtask : flip

  // Hang guard: the tests need well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) rdchk(IDX[i], 8'h00);
    rdchk(8'h20, 8'h00);
    check(irq_o, 1'b0);
    wb(IDX[1], 1'b1, 8'h0F);
    // Per group: mask lane, masked neighbour, rise and fall, clear by one only
    for (int k = 0; k < 4; k++) begin
      wb(IDX[k + 2], 1'b1, 8'h01 << k);
      rdchk(IDX[k + 2], 8'h01 << k);
      flip(32'h2 << (9 * k));
      rdchk(IDX[0], 8'h00);
      flip(32'h1 << (9 * k));
      rdchk(IDX[0], 8'h01 << k);
      check(irq_o, 1'b0);
      wb(IDX[0], 1'b1, ~(8'h01 << k));
      rdchk(IDX[0], 8'h01 << k);
      wb(IDX[0], 1'b1, 8'h01 << k);
      rdchk(IDX[0], 8'h00);
      flip(32'h1 << (9 * k));
      rdchk(IDX[0], 8'h01 << k);
      wb(IDX[0], 1'b1, 8'h0F);
    end
    // Group 0 disabled: its watched pin no longer sets the flag
    wb(IDX[1], 1'b1, 8'h0E);
    flip(32'h1);
    rdchk(IDX[0], 8'h00);
    lane = 4'h2;
    wb(IDX[1], 1'b1, 8'h00);
    lane = 4'h1;
    wb(8'h20, 1'b1, 8'hFF);
    rdchk(IDX[1], 8'h0E);
    // Two groups pending; global enable gates the requests, lowest group first
    flip(32'h0004_0200);
    check(req_o, 4'h0);
    gie <= 1'b1;
    repeat (2) @(posedge clk_i);
    check(req_o, 4'h6);
    check(irq_o, 1'b1);
    check({29'h0, vec}, 32'h5);
    serve <= 1'b1;
    repeat (14) @(posedge clk_i);
    rdchk(IDX[0], 8'h00);
    check(irq_o, 1'b0);
    // Clock enable low: a watched change waits until the unit runs again
    serve <= 1'b0;
    ce    <= 1'b0;
    flip(32'h0000_0200);
    check(req_o, 4'h0);
    ce <= 1'b1;
    flip(32'h0);
    check(req_o, 4'h2);
    // Reset in mid-run clears enables, flags and masks again
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) rdchk(IDX[i], 8'h00);
    check(irq_o, 1'b0);
    complete_run();
  end
endmodule : tb_pin_change_irq
